// *** logic/uec_axil.sv ***
`timescale 1ns/1ps
module uec_axil (
  input wire logic clock,
  input wire logic rst,
  input wire logic [uec_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [uec_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  uec_reg_if.bus reg_port
);
  logic [7:0] aw_addr;
  logic [7:0] w_data;
  logic w_lane0;
  logic both_held;
  // Address and data are taken in either order; the write fires once both are held and byte lane 0 is strobed
  assign both_held = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign reg_port.wr = both_held & w_lane0;
  assign reg_port.waddr = aw_addr;
  assign reg_port.wdata = w_data;
  assign reg_port.raddr = s_axi_araddr;

  always_ff @(posedge clock) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= uec_pkg::AXI_OKAY;
      aw_addr <= 8'h00;
      w_data <= 8'h00;
      w_lane0 <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (both_held) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= reg_port.whit ? uec_pkg::AXI_OKAY : uec_pkg::AXI_DECERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= uec_pkg::AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, reg_port.rdata};
      s_axi_rresp <= reg_port.rhit ? uec_pkg::AXI_OKAY : uec_pkg::AXI_DECERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule : uec_axil

// *** logic/uec_ep_resp.sv ***
`timescale 1ns/1ps
module uec_ep_resp (
  input wire logic [1:0] tok_pid,
  input wire logic [6:0] tok_addr,
  input wire logic [3:0] tok_ep,
  input wire logic [3:0] out_len,
  input wire logic [6:0] dev_addr,
  input wire logic ctr_flag,
  input wire logic [2:0][7:0] tx_ctrl,
  input wire logic [2:0][7:0] rx_ctrl,
  output uec_pkg::uec_resp_t code,
  output logic [1:0] ep_idx
);
  function automatic uec_pkg::uec_resp_t gate(input logic [1:0] st, input logic busy,
                                               input uec_pkg::uec_resp_t ok);
    unique case (st)
      uec_pkg::UEC_STAT_DISABLED: gate = uec_pkg::UEC_RESP_NONE;
      uec_pkg::UEC_STAT_STALL: gate = uec_pkg::UEC_RESP_STALL;
      uec_pkg::UEC_STAT_NAK: gate = uec_pkg::UEC_RESP_NAK;
      uec_pkg::UEC_STAT_VALID: gate = busy ? uec_pkg::UEC_RESP_NAK : ok;
    endcase
  endfunction : gate

  logic addr_ok;
  logic ep0_hit;
  logic ep1_hit;
  logic ep2_hit;
  logic found;
  logic is_control;
  logic status_stall;
  logic [7:0] tx_sel;
  logic [7:0] rx_sel;
  uec_pkg::uec_resp_t out_ok;
  assign addr_ok = tok_addr == dev_addr;
  assign ep0_hit = tok_ep == 4'h0;
  assign ep1_hit = rx_ctrl[1][3:0] == tok_ep;
  assign ep2_hit = rx_ctrl[2][3:0] == tok_ep;
  assign found = addr_ok & (ep0_hit | ep1_hit | ep2_hit);
  assign ep_idx = ep0_hit ? 2'h0 : (ep1_hit ? 2'h1 : 2'h2);
  assign tx_sel = tx_ctrl[ep_idx];
  assign rx_sel = rx_ctrl[ep_idx];
  assign is_control = (ep_idx == 2'h0) | rx_sel[uec_pkg::BIT_CONTROL_TYPE];
  assign status_stall = tx_sel[uec_pkg::BIT_STATUS_STAGE] & (out_len != 4'h0);
  assign out_ok = status_stall ? uec_pkg::UEC_RESP_STALL : uec_pkg::UEC_RESP_ACK;

  always_comb begin
    code = uec_pkg::UEC_RESP_NONE;
    if (found) begin
      unique case (tok_pid)
        uec_pkg::UEC_TOK_IN: code = gate(tx_sel[5:4], ctr_flag, uec_pkg::UEC_RESP_DATA);
        uec_pkg::UEC_TOK_OUT: code = gate(rx_sel[5:4], ctr_flag, out_ok);
        uec_pkg::UEC_TOK_SETUP: begin
          if (is_control) begin
            code = gate(rx_sel[5:4], ctr_flag, uec_pkg::UEC_RESP_ACK);
          end
        end
        default: code = uec_pkg::UEC_RESP_NONE;
      endcase
    end
  end
endmodule : uec_ep_resp

// *** logic/uec_top.sv ***
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module uec_top (
  input wire logic clock,
  input wire logic rst,
  input wire logic [uec_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [uec_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic usb_reset_evt,
  input wire logic tok_valid,
  input wire logic [1:0] tok_pid,
  input wire logic [6:0] tok_addr,
  input wire logic [3:0] tok_ep,
  input wire logic [3:0] out_len,
  input wire logic data_pid,
  input wire logic xfer_ok,
  input wire logic dma_step,
  output logic resp_valid,
  output logic [2:0] resp_code,
  output logic resp_data_pid,
  output logic [3:0] resp_len,
  output logic [15:0] dma_addr,
  output logic iface_in_reset,
  output logic correct_transfer_flag
);
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = a[7:2] == off[7:2];
  endfunction : hit

  function automatic logic [7:0] ep_off(input int n, input logic rx);
    ep_off = uec_pkg::OFF_EP_BASE + 8'(n) * uec_pkg::EP_STRIDE
             + (rx ? uec_pkg::EP_RX_DELTA : 8'h00);
  endfunction : ep_off

  uec_reg_if reg_port ();

  uec_axil u_axil (
    .clock(clock),
    .rst(rst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .reg_port(reg_port.bus)
  );

  // Register state
  logic [6:0] dev_addr;
  logic [2:0][7:0] tx_ctrl;
  logic [2:0][7:0] rx_ctrl;
  logic [2:0][7:0] next_tx;
  logic [2:0][7:0] next_rx;
  logic [7:0] base_high;
  logic [1:0] base_low;
  logic [1:0] cap_tok;
  logic [1:0] cap_ep;
  logic forced_interface_reset;
  logic reset_flag;

  // Pending transaction, kept from the token until its outcome
  logic pend_valid;
  logic [1:0] pend_pid;
  logic [1:0] pend_ep;

  logic usb_rst;
  logic done;
  logic done_ok;
  logic out_match;
  logic release_evt;
  logic ev_clear_ctr;
  logic ev_clear_rst;
  logic wr_device_address;
  logic wr_base_high;
  logic wr_identity;
  logic wr_control;
  logic wr_events;
  logic [2:0] wr_tx;
  logic [2:0] wr_rx;
  logic [2:0] rd_tx;
  logic [2:0] rd_rx;
  logic [7:0] wd;
  logic [7:0] ra;
  logic [15:0] buf_start;
  uec_pkg::uec_resp_t code;
  logic [1:0] ep_idx;
  logic accept;

  assign usb_rst = usb_reset_evt | forced_interface_reset;
  assign wd = reg_port.wdata;
  assign ra = reg_port.raddr;

  // Write decode
  assign wr_device_address = reg_port.wr & hit(reg_port.waddr, uec_pkg::OFF_DEVICE_ADDRESS);
  assign wr_base_high = reg_port.wr & hit(reg_port.waddr, uec_pkg::OFF_BUFFER_BASE_HIGH);
  assign wr_identity = reg_port.wr & hit(reg_port.waddr, uec_pkg::OFF_TRANSFER_IDENTITY);
  assign wr_control = reg_port.wr & hit(reg_port.waddr, uec_pkg::OFF_INTERFACE_CONTROL);
  assign wr_events = reg_port.wr & hit(reg_port.waddr, uec_pkg::OFF_EVENT_FLAGS);

  for (genvar g = 0; g < 3; g++) begin : g_dec
    assign wr_tx[g] = reg_port.wr & hit(reg_port.waddr, ep_off(g, 1'b0));
    assign wr_rx[g] = reg_port.wr & hit(reg_port.waddr, ep_off(g, 1'b1));
    assign rd_tx[g] = hit(ra, ep_off(g, 1'b0));
    assign rd_rx[g] = hit(ra, ep_off(g, 1'b1));
  end

  assign reg_port.whit = hit(reg_port.waddr, uec_pkg::OFF_DEVICE_ADDRESS)
                         | hit(reg_port.waddr, uec_pkg::OFF_BUFFER_BASE_HIGH)
                         | hit(reg_port.waddr, uec_pkg::OFF_TRANSFER_IDENTITY)
                         | hit(reg_port.waddr, uec_pkg::OFF_TOKEN_TYPE)
                         | hit(reg_port.waddr, uec_pkg::OFF_INTERFACE_CONTROL)
                         | hit(reg_port.waddr, uec_pkg::OFF_EVENT_FLAGS)
                         | (|wr_tx) | (|wr_rx)
                         | (reg_port.waddr[7:2] > 6'h00 && reg_port.waddr[7:2] < 6'h07);

  // Read mux; unmapped words read zero with an error response
  assign reg_port.rhit = hit(ra, uec_pkg::OFF_DEVICE_ADDRESS) | (|rd_tx) | (|rd_rx)
                         | hit(ra, uec_pkg::OFF_BUFFER_BASE_HIGH)
                         | hit(ra, uec_pkg::OFF_TRANSFER_IDENTITY)
                         | hit(ra, uec_pkg::OFF_TOKEN_TYPE)
                         | hit(ra, uec_pkg::OFF_INTERFACE_CONTROL)
                         | hit(ra, uec_pkg::OFF_EVENT_FLAGS);
  assign reg_port.rdata =
      hit(ra, uec_pkg::OFF_DEVICE_ADDRESS) ? {1'b0, dev_addr} :
      rd_tx[0] ? tx_ctrl[0] :
      rd_rx[0] ? {1'b1, rx_ctrl[0][6:4], 4'h0} :
      rd_tx[1] ? tx_ctrl[1] :
      rd_rx[1] ? rx_ctrl[1] :
      rd_tx[2] ? tx_ctrl[2] :
      rd_rx[2] ? rx_ctrl[2] :
      hit(ra, uec_pkg::OFF_BUFFER_BASE_HIGH) ? base_high :
      hit(ra, uec_pkg::OFF_TRANSFER_IDENTITY) ? {base_low, cap_ep, 4'h0} :
      hit(ra, uec_pkg::OFF_TOKEN_TYPE) ? {cap_tok, 6'h00} :
      hit(ra, uec_pkg::OFF_INTERFACE_CONTROL) ? {7'h00, forced_interface_reset} :
      hit(ra, uec_pkg::OFF_EVENT_FLAGS) ? {6'h00, reset_flag, correct_transfer_flag} :
      8'h00;

  // Token answer
  uec_ep_resp u_resp (
    .tok_pid(tok_pid),
    .tok_addr(tok_addr),
    .tok_ep(tok_ep),
    .out_len(out_len),
    .dev_addr(dev_addr),
    .ctr_flag(correct_transfer_flag),
    .tx_ctrl(tx_ctrl),
    .rx_ctrl(rx_ctrl),
    .code(code),
    .ep_idx(ep_idx)
  );

  // Only a data packet sent or an ACK given can later become a correct transfer
  assign accept = tok_valid & ~usb_rst
                  & (code == uec_pkg::UEC_RESP_DATA || code == uec_pkg::UEC_RESP_ACK);
  assign done = xfer_ok & pend_valid & ~usb_rst;
  assign out_match = data_pid == rx_ctrl[pend_ep][uec_pkg::BIT_TOGGLE];
  // A mismatched OUT toggle is a repeat of old data, not a correct transfer
  assign done_ok = done & ((pend_pid != uec_pkg::UEC_TOK_OUT) | out_match);
  assign release_evt = wr_control & ~wd[uec_pkg::BIT_FORCED_RESET] & forced_interface_reset;
  assign ev_clear_ctr = wr_events & wd[uec_pkg::BIT_EV_CORRECT];
  assign ev_clear_rst = wr_events & wd[uec_pkg::BIT_EV_RESET];
  assign buf_start = {base_high, base_low, 6'h00};

  // Endpoint control next state: bus reset, then hardware update, then software
  always_comb begin
    next_tx = tx_ctrl;
    next_rx = rx_ctrl;
    for (int i = 0; i < 3; i++) begin
      if (wr_tx[i]) begin
        next_tx[i] = wd;
      end
      if (wr_rx[i]) begin
        next_rx[i] = (i == 0) ? {1'b1, wd[6:4], 4'h0} : wd;
      end
      if (done_ok && pend_ep == 2'(i)) begin
        unique case (pend_pid)
          uec_pkg::UEC_TOK_IN: begin
            next_tx[i][uec_pkg::BIT_TOGGLE] = ~tx_ctrl[i][uec_pkg::BIT_TOGGLE];
            next_tx[i][5:4] = uec_pkg::UEC_STAT_NAK;
          end
          uec_pkg::UEC_TOK_OUT: begin
            next_rx[i][uec_pkg::BIT_TOGGLE] = ~rx_ctrl[i][uec_pkg::BIT_TOGGLE];
            next_rx[i][5:4] = uec_pkg::UEC_STAT_NAK;
          end
          uec_pkg::UEC_TOK_SETUP: begin
            next_tx[i][uec_pkg::BIT_TOGGLE] = 1'b1;
            // Cleared for the DATA0 setup packet, then flipped by its arrival
            next_rx[i][uec_pkg::BIT_TOGGLE] = 1'b1;
            next_tx[i][5:4] = uec_pkg::UEC_STAT_NAK;
            next_rx[i][5:4] = uec_pkg::UEC_STAT_NAK;
          end
          default: begin
            next_tx[i] = tx_ctrl[i];
          end
        endcase
      end
      if (usb_rst) begin
        next_tx[i] = uec_pkg::RST_TX_CONTROL;
        next_rx[i] = (i == 0) ? uec_pkg::RST_EP0_RX_CONTROL : uec_pkg::RST_RX_CONTROL;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      tx_ctrl <= {3{uec_pkg::RST_TX_CONTROL}};
      rx_ctrl <= {uec_pkg::RST_RX_CONTROL, uec_pkg::RST_RX_CONTROL,
                  uec_pkg::RST_EP0_RX_CONTROL};
    end else begin
      tx_ctrl <= next_tx;
      rx_ctrl <= next_rx;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || usb_rst) begin
      dev_addr <= uec_pkg::RST_DEVICE_ADDRESS[6:0];
    end else if (wr_device_address) begin
      dev_addr <= wd[6:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      base_high <= 8'h00;
      base_low <= 2'h0;
      forced_interface_reset <= 1'b0;
    end else begin
      if (wr_base_high) begin
        base_high <= wd;
      end
      if (wr_identity) begin
        base_low <= wd[7:6];
      end
      if (wr_control) begin
        forced_interface_reset <= wd[uec_pkg::BIT_FORCED_RESET];
      end
    end
  end

  // Event flags: a hardware set in the same cycle as a clear wins
  always_ff @(posedge clock) begin
    if (rst) begin
      correct_transfer_flag <= 1'b0;
      reset_flag <= 1'b0;
    end else begin
      correct_transfer_flag <= done_ok | (correct_transfer_flag & ~ev_clear_ctr);
      reset_flag <= usb_reset_evt | release_evt | (reset_flag & ~ev_clear_rst);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cap_tok <= 2'h0;
      cap_ep <= 2'h0;
    end else if (done_ok && !correct_transfer_flag) begin
      cap_tok <= pend_pid;
      cap_ep <= pend_ep;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || usb_rst) begin
      pend_valid <= 1'b0;
      pend_pid <= uec_pkg::UEC_TOK_OUT;
      pend_ep <= 2'h0;
    end else if (tok_valid) begin
      pend_valid <= accept;
      pend_pid <= tok_pid;
      pend_ep <= ep_idx;
    end else if (done) begin
      pend_valid <= 1'b0;
    end
  end

  // Answer to the link, one cycle after the token
  always_ff @(posedge clock) begin
    if (rst) begin
      resp_valid <= 1'b0;
      resp_code <= uec_pkg::UEC_RESP_NONE;
      resp_data_pid <= 1'b0;
      resp_len <= 4'h0;
    end else begin
      resp_valid <= tok_valid & ~usb_rst;
      resp_code <= usb_rst ? uec_pkg::UEC_RESP_NONE : code;
      resp_data_pid <= tx_ctrl[ep_idx][uec_pkg::BIT_TOGGLE];
      resp_len <= tx_ctrl[ep_idx][3:0];
    end
  end

  // Buffer pointer: each slot starts at offset 000 and walks upward
  always_ff @(posedge clock) begin
    if (rst) begin
      dma_addr <= 16'h0000;
    end else if (accept) begin
      dma_addr <= buf_start | {10'h000, ep_idx, tok_pid == uec_pkg::UEC_TOK_IN, 3'h0};
    end else if (dma_step) begin
      dma_addr <= dma_addr + 16'h0001;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      iface_in_reset <= 1'b0;
    end else begin
      iface_in_reset <= usb_rst;
    end
  end
endmodule : uec_top

// *** pkg/uec_pkg.sv ***
package uec_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_DEVICE_ADDRESS = 8'h00;
  localparam logic [7:0] OFF_EP_BASE = 8'h04;
  localparam logic [7:0] EP_STRIDE = 8'h08;
  localparam logic [7:0] EP_RX_DELTA = 8'h04;
  localparam logic [7:0] OFF_BUFFER_BASE_HIGH = 8'h1C;
  localparam logic [7:0] OFF_TRANSFER_IDENTITY = 8'h20;
  localparam logic [7:0] OFF_TOKEN_TYPE = 8'h24;
  localparam logic [7:0] OFF_INTERFACE_CONTROL = 8'h28;
  localparam logic [7:0] OFF_EVENT_FLAGS = 8'h2C;
  localparam logic [7:0] RST_DEVICE_ADDRESS = 8'h00;
  localparam logic [7:0] RST_TX_CONTROL = 8'h00;
  localparam logic [7:0] RST_RX_CONTROL = 8'h00;
  localparam logic [7:0] RST_EP0_RX_CONTROL = 8'h80;
  localparam int BIT_STATUS_STAGE = 7;
  localparam int BIT_CONTROL_TYPE = 7;
  localparam int BIT_TOGGLE = 6;
  localparam int BIT_EV_CORRECT = 0;
  localparam int BIT_EV_RESET = 1;
  localparam int BIT_FORCED_RESET = 0;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_DECERR = 2'h3;
  typedef enum logic [1:0] {
    UEC_STAT_DISABLED = 2'b00,
    UEC_STAT_STALL = 2'b01,
    UEC_STAT_NAK = 2'b10,
    UEC_STAT_VALID = 2'b11
  } uec_stat_t;
  typedef enum logic [1:0] {
    UEC_TOK_OUT = 2'b00,
    UEC_TOK_BAD = 2'b01,
    UEC_TOK_IN = 2'b10,
    UEC_TOK_SETUP = 2'b11
  } uec_tok_t;
  typedef enum logic [2:0] {
    UEC_RESP_NONE = 3'b000,
    UEC_RESP_ACK = 3'b001,
    UEC_RESP_NAK = 3'b010,
    UEC_RESP_STALL = 3'b011,
    UEC_RESP_DATA = 3'b100
  } uec_resp_t;
endpackage : uec_pkg

// *** pkg/uec_reg_if.sv ***
`timescale 1ns/1ps
interface uec_reg_if;
  logic wr;
  logic [7:0] waddr;
  logic [7:0] wdata;
  logic whit;
  logic [7:0] raddr;
  logic [7:0] rdata;
  logic rhit;
  modport bus (output wr, waddr, wdata, raddr, input whit, rdata, rhit);
  modport regs (input wr, waddr, wdata, raddr, output whit, rdata, rhit);
endinterface : uec_reg_if

// *** verification/uec_host.sv ***
`timescale 1ns/1ps
module uec_host (
  input wire logic clock,
  output logic tok_valid,
  output logic [1:0] tok_pid,
  output logic [6:0] tok_addr,
  output logic [3:0] tok_ep,
  output logic [3:0] out_len,
  output logic data_pid,
  output logic xfer_ok,
  output logic dma_step
);
  initial begin
    tok_valid = 1'b0;
    xfer_ok = 1'b0;
    dma_step = 1'b0;
    {tok_pid, tok_addr, tok_ep, out_len, data_pid} = '0;
  end
  // Idle fields carry the inverse so a stale token is never mistaken for a live one
  task automatic token(input logic [1:0] p, input logic [6:0] a, input logic [3:0] e,
                       input logic [3:0] n);
    tok_valid <= 1'b1;
    {tok_pid, tok_addr, tok_ep, out_len} <= {p, a, e, n};
    @(posedge clock);
    tok_valid <= 1'b0;
    {tok_pid, tok_addr, tok_ep, out_len} <= ~{p, a, e, n};
  endtask : token
  task automatic done(input logic d);
    xfer_ok <= 1'b1;
    dma_step <= 1'b1;
    data_pid <= d;
    @(posedge clock);
    xfer_ok <= 1'b0;
    dma_step <= 1'b0;
    data_pid <= ~d;
  endtask : done
endmodule : uec_host

// *** verification/uec_monitor.sv ***
`timescale 1ns/1ps
module uec_monitor (
  input wire logic clock,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic usb_reset_evt,
  input wire logic tok_valid,
  input wire logic xfer_ok,
  input wire logic resp_valid,
  input wire logic [2:0] resp_code,
  input wire logic [15:0] dma_addr,
  input wire logic iface_in_reset,
  input wire logic correct_transfer_flag
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  write_answer_a: assert property (aw_w_taken |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  read_answer_a: assert property (ar_taken |=> s_axi_rvalid)
    else $error("read answer late");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  resp_cause_a: assert property (resp_valid |->
    $past(tok_valid) && !$past(usb_reset_evt)) else $error("answer without token");
  reset_hold_a: assert property (usb_reset_evt |=> iface_in_reset && !resp_valid)
    else $error("bus reset not held");
  flag_cause_a: assert property ($rose(correct_transfer_flag) |-> $past(xfer_ok))
    else $error("flag without transfer");
  flag_nak_a: assert property (correct_transfer_flag && tok_valid |=>
    !resp_valid || resp_code inside {3'h0, 3'h2, 3'h3}) else $error("valid answer under flag");
  buffer_low_a: assert property (resp_valid && resp_code == 3'h4 |->
    dma_addr[3:0] == 4'h8) else $error("buffer start wrong");
endmodule : uec_monitor
bind uec_top uec_monitor i_mon (.clock, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .usb_reset_evt, .tok_valid, .xfer_ok, .resp_valid, .resp_code, .dma_addr,
  .iface_in_reset, .correct_transfer_flag);

// *** verification/usb_endpoint_control_tb.sv ***
`timescale 1ns/1ps
module usb_endpoint_control_tb;
  localparam logic [7:0] DA = uec_pkg::OFF_DEVICE_ADDRESS;
  localparam logic [7:0] TX0 = uec_pkg::OFF_EP_BASE;
  localparam logic [7:0] RX0 = TX0 + uec_pkg::EP_RX_DELTA;
  localparam logic [7:0] RX1 = RX0 + uec_pkg::EP_STRIDE;
  localparam logic [7:0] TOK = uec_pkg::OFF_TOKEN_TYPE;
  localparam logic [7:0] EV = uec_pkg::OFF_EVENT_FLAGS;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  // Answer readies stay high, so back-to-back calls never drive them twice in one step
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1, usb_reset_evt = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  wire tok_valid, data_pid, xfer_ok, dma_step;
  wire [1:0] tok_pid;
  wire [6:0] tok_addr;
  wire [3:0] tok_ep, out_len;
  logic resp_valid, resp_data_pid, iface_in_reset, correct_transfer_flag;
  logic [2:0] resp_code;
  logic [3:0] resp_len;
  logic [15:0] dma_addr;
  logic [6:0] dev;
  logic [3:0] n, m, len;
  logic [20:0] seen;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  uec_top i_dut (.clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .usb_reset_evt, .tok_valid, .tok_pid, .tok_addr, .tok_ep, .out_len,
    .data_pid, .xfer_ok, .dma_step, .resp_valid, .resp_code, .resp_data_pid, .resp_len,
    .dma_addr, .iface_in_reset, .correct_transfer_flag);
  uec_host i_host (.clock, .tok_valid, .tok_pid, .tok_addr, .tok_ep, .out_len, .data_pid,
    .xfer_ok, .dma_step);
  initial begin
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc > 6000) begin
      error_cnt++;
      end_sim();
    end
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task automatic chk(input logic ok);
    check_count++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("Error at %0t: value differs from expected", $time);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    chk(s_axi_bresp === uec_pkg::AXI_OKAY);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] r = 2'h0);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata === {24'h0, e} && s_axi_rresp === r);
  endtask : rd
  function automatic logic [2:0] ecode(input logic [1:0] s, input logic in);
    case (s)
      2'b00: ecode = 3'h0;
      2'b01: ecode = 3'h3;
      2'b10: ecode = 3'h2;
      default: ecode = in ? 3'h4 : 3'h1;
    endcase
  endfunction : ecode
  // Every token outside bus reset gets an answer strobe; silence is code none
  task automatic tok(input logic [1:0] p, input logic [3:0] e, input logic [3:0] l,
                     input logic [2:0] x);
    i_host.token(p, dev, e, l);
    @(negedge clock);
    seen = {resp_data_pid, resp_len, dma_addr};
    chk(resp_valid === 1'b1 && resp_code === x);
    @(posedge clock);
  endtask : tok
  initial begin
    void'($urandom(32'h1BE6));
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(RX0, 8'h80);
    rd(DA, 8'h00);
    dev = 7'($urandom);
    wr(DA, {1'b1, dev});
    rd(DA, {1'b0, dev});
    wr(RX0, 8'hFF);
    rd(RX0, 8'hF0);
    rd(8'h30, 8'h00, uec_pkg::AXI_DECERR);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      wr(TX0, {2'b00, 2'(i), 4'h0});
      wr(RX0, {2'b00, 2'(i), 4'h0});
      tok(2'b10, 4'h0, 4'h0, ecode(2'(i), 1'b1));
      tok(2'b00, 4'h0, 4'h0, ecode(2'(i), 1'b0));
    end
    $display("test handshake decode done");
    n = 4'($urandom % 9);
    wr(uec_pkg::OFF_BUFFER_BASE_HIGH, 8'hA5);
    wr(uec_pkg::OFF_TRANSFER_IDENTITY, 8'h80);
    wr(TX0, {4'h3, n});
    tok(2'b10, 4'h0, 4'h0, 3'h4);
    chk(seen === {1'b0, n, 16'hA588});
    i_host.done(1'b0);
    rd(TX0, {4'h6, n});
    chk(correct_transfer_flag === 1'b1);
    wr(TX0, {4'h7, n});
    tok(2'b10, 4'h0, 4'h0, 3'h2);
    rd(TOK, 8'h80);
    wr(EV, 8'h01);
    tok(2'b10, 4'h0, 4'h0, 3'h4);
    chk(seen[20] === 1'b1);
    $display("test in transfer done");
    wr(RX0, 8'h30);
    tok(2'b11, 4'h0, 4'h0, 3'h1);
    i_host.done(1'b0);
    rd(TOK, 8'hC0);
    rd(TX0, {4'h6, n});
    rd(RX0, 8'hE0);
    wr(EV, 8'h01);
    $display("test setup done");
    wr(TX0, {4'h8, n});
    wr(RX0, 8'h30);
    len = 4'(1 + $urandom % 8);
    tok(2'b00, 4'h0, len, 3'h3);
    tok(2'b00, 4'h0, 4'h0, 3'h1);
    m = 4'(1 + $urandom % 14);
    wr(RX1, {4'h3, m});
    tok(2'b00, m, 4'h0, 3'h1);
    tok(2'b00, m + 4'h1, 4'h0, 3'h0);
    dev = dev + 7'h1;
    tok(2'b00, m, 4'h0, 3'h0);
    $display("test out and match done");
    usb_reset_evt <= 1'b1;
    repeat (3) @(posedge clock);
    chk(iface_in_reset === 1'b1);
    usb_reset_evt <= 1'b0;
    rd(DA, 8'h00);
    rd(RX0, 8'h80);
    rd(RX1, 8'h00);
    rd(EV, 8'h02);
    dev = 7'h00;
    tok(2'b10, 4'h0, 4'h0, 3'h0);
    wr(EV, 8'h02);
    rd(EV, 8'h00);
    wr(uec_pkg::OFF_INTERFACE_CONTROL, 8'h01);
    repeat (2) @(posedge clock);
    chk(iface_in_reset === 1'b1);
    wr(uec_pkg::OFF_INTERFACE_CONTROL, 8'h00);
    rd(EV, 8'h02);
    wr(RX0, 8'h30);
    tok(2'b00, 4'h0, 4'h0, 3'h1);
    $display("test bus reset done");
    end_sim();
  end
endmodule : usb_endpoint_control_tb
